//--- logic/jtag_isp_tap_port.v
// Test access port with identification, bypass and in-system programming.
// Assumes tck, tms, tdi arrive asynchronously and are sampled by sys_clk,
// which must run several times faster than tck. Pin tri-state is resolved
// outside from the enables.
//
// Operation
// [R1] Code 1111 puts one-bit bypass stage
// [R2] All-ones instruction scan selects bypass
// [R3] Code 0001 shifts identification word out
// [R4] No test reset pin; power-up reset
// [R5] Sample tdi on rising tck
// [R6] Change tdo on falling tck
// [R7] Drive tdo only while shifting
// [R8] Controller keeps tms high outside use
// [R9] Code 1001 arms programming engine
// [R10] Enable precedes erase, program, verify
// [R11] Code 1010 erases whole array
// [R12] Code 1011 writes shifter to row
// [R13] Code 1100 reads row into shifter
// [R14] Pins default test; config frees them
// [R15] Pin cells stay usable as buried logic
// [R16] Sixteen-state controller, IR resets identification
// [R17] Unknown codes act as bypass
`include "tap_port_regs.vh"

module jtag_isp_tap_port #(
    parameter [31:0] ID_VALUE = 32'h0000_1001  // Arbitrary identification value
) (
    input  wire                        sys_clk,
    input  wire                        rst,
    input  wire                        tck,
    input  wire                        tms,
    input  wire                        tdi,
    output reg                         tdo,
    output reg                         tdo_oe,
    input  wire                        test_port_disable,
    input  wire [3:0]                  user_out,
    input  wire [3:0]                  user_oe,
    output wire [3:0]                  pin_out,
    output wire [3:0]                  pin_oe,
    output wire [3:0]                  user_in,
    output wire [3:0]                  buried_in,
    input  wire [`ROW_ADDR_WIDTH-1:0]  row_addr,
    output reg                         prog_armed,
    output reg  [`ROW_WIDTH-1:0]       row_read_data
);

    // ========================================================
    // Pin synchronisers and tck edges
    // ========================================================
    reg  [2:0] sync1;
    reg  [2:0] sync2;
    reg        tck_prev;
    reg        port_off;
    wire       tck_s  = sync2[2];
    wire       tms_s  = sync2[1];
    wire       tdi_s  = sync2[0];
    wire       tck_rise = tck_s & ~tck_prev & ~port_off;
    wire       tck_fall = ~tck_s & tck_prev & ~port_off;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1    <= 3'h7;
            sync2    <= 3'h7;
            tck_prev <= 1'b1;
        end else begin
            sync1    <= {tck, tms, tdi};
            sync2    <= sync1;
            tck_prev <= tck_s;
        end
    end

    // ========================================================
    // Pin ownership
    // ========================================================
    // [R14] Test by default; once disabled, stays general I/O
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_off <= 1'b0;
        end else if (test_port_disable) begin
            port_off <= 1'b1;
        end
    end

    // Pins are tck, tms, tdi, tdo in bits 3..0; only tdo is an output in test use
    assign pin_out   = port_off ? user_out : {3'h0, tdo};
    assign pin_oe    = port_off ? user_oe : {3'h0, tdo_oe};
    assign user_in   = port_off ? {tck, tms, tdi, 1'b0} : 4'h0;
    // [R15] Cell logic stays usable as buried logic
    assign buried_in = user_out;

    // ========================================================
    // TAP controller
    // ========================================================
    reg [3:0] state;
    reg [3:0] next_state;

    // [R16] Standard sixteen-state sequence
    always @* begin
        case (state)
            `ST_RESET: begin
                if (tms_s) begin
                    next_state = `ST_RESET;
                end else begin
                    next_state = `ST_IDLE;
                end
            end
            `ST_IDLE: begin
                if (tms_s) begin
                    next_state = `ST_SEL_DR;
                end else begin
                    next_state = `ST_IDLE;
                end
            end
            `ST_SEL_DR: begin
                if (tms_s) begin
                    next_state = `ST_SEL_IR;
                end else begin
                    next_state = `ST_CAP_DR;
                end
            end
            `ST_CAP_DR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT1_DR;
                end else begin
                    next_state = `ST_SHIFT_DR;
                end
            end
            `ST_SHIFT_DR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT1_DR;
                end else begin
                    next_state = `ST_SHIFT_DR;
                end
            end
            `ST_EXIT1_DR: begin
                if (tms_s) begin
                    next_state = `ST_UPD_DR;
                end else begin
                    next_state = `ST_PAUSE_DR;
                end
            end
            `ST_PAUSE_DR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT2_DR;
                end else begin
                    next_state = `ST_PAUSE_DR;
                end
            end
            `ST_EXIT2_DR: begin
                if (tms_s) begin
                    next_state = `ST_UPD_DR;
                end else begin
                    next_state = `ST_SHIFT_DR;
                end
            end
            `ST_UPD_DR: begin
                if (tms_s) begin
                    next_state = `ST_SEL_DR;
                end else begin
                    next_state = `ST_IDLE;
                end
            end
            `ST_SEL_IR: begin
                if (tms_s) begin
                    next_state = `ST_RESET;
                end else begin
                    next_state = `ST_CAP_IR;
                end
            end
            `ST_CAP_IR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT1_IR;
                end else begin
                    next_state = `ST_SHIFT_IR;
                end
            end
            `ST_SHIFT_IR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT1_IR;
                end else begin
                    next_state = `ST_SHIFT_IR;
                end
            end
            `ST_EXIT1_IR: begin
                if (tms_s) begin
                    next_state = `ST_UPD_IR;
                end else begin
                    next_state = `ST_PAUSE_IR;
                end
            end
            `ST_PAUSE_IR: begin
                if (tms_s) begin
                    next_state = `ST_EXIT2_IR;
                end else begin
                    next_state = `ST_PAUSE_IR;
                end
            end
            `ST_EXIT2_IR: begin
                if (tms_s) begin
                    next_state = `ST_UPD_IR;
                end else begin
                    next_state = `ST_SHIFT_IR;
                end
            end
            default: begin
                if (tms_s) begin
                    next_state = `ST_SEL_DR;
                end else begin
                    next_state = `ST_IDLE;
                end
            end
        endcase
    end

    // ========================================================
    // Registers on rising tck; row read-back register updated every sys_clk
    // ========================================================
    reg  [3:0]             ir_shift;
    reg  [3:0]             ir;
    reg                    bypass_bit;
    reg  [31:0]            id_shift;
    reg  [`ROW_WIDTH-1:0]  prog_shift;
    reg  [`ROW_WIDTH-1:0]  rows [0:(1<<`ROW_ADDR_WIDTH)-1];
    integer                i;

    wire is_prog = (ir == `INSN_ENABLE) || (ir == `INSN_ERASE) ||
                   (ir == `INSN_PROGRAM) || (ir == `INSN_VERIFY);
    wire is_id   = (ir == `INSN_IDCODE);
    // [R1] [R17] Bypass for 1111 and any unknown code
    wire is_byp  = !is_prog && !is_id;

    // [R4] Power-up reset puts the test logic in reset
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state       <= `ST_RESET;
            ir_shift    <= 4'h0;
            ir          <= `IR_RESET_VALUE;
            bypass_bit  <= 1'b0;
            id_shift    <= 32'h0;
            prog_shift  <= {`ROW_WIDTH{1'b0}};
            prog_armed  <= 1'b0;
            for (i = 0; i < (1 << `ROW_ADDR_WIDTH); i = i + 1) begin
                rows[i] <= {`ROW_WIDTH{1'b0}};
            end
        end else if (tck_rise) begin
            // [R5] Sample on rising tck
            state <= next_state;
            case (state)
                `ST_RESET: begin
                    // [R16] Reset selects identification
                    ir         <= `IR_RESET_VALUE;
                    prog_armed <= 1'b0;
                end
                `ST_CAP_IR: ir_shift <= `IR_CAPTURE_VALUE;
                // [R2] All-ones tdi leaves 1111 in the shifter
                `ST_SHIFT_IR: ir_shift <= {tdi_s, ir_shift[3:1]};
                `ST_UPD_IR: begin
                    ir <= ir_shift;
                    // [R9] Enable arms the engine
                    if (ir_shift == `INSN_ENABLE) begin
                        prog_armed <= 1'b1;
                    end
                end
                `ST_CAP_DR: begin
                    bypass_bit <= 1'b0;
                    id_shift   <= ID_VALUE;
                    // [R13] Verify copies row to shifter
                    if (ir == `INSN_VERIFY && prog_armed) begin
                        prog_shift <= rows[row_addr];
                    end
                end
                `ST_SHIFT_DR: begin
                    bypass_bit <= tdi_s;
                    // [R3] Identification shifts toward tdo
                    id_shift   <= {tdi_s, id_shift[31:1]};
                    prog_shift <= {tdi_s, prog_shift[`ROW_WIDTH-1:1]};
                end
                `ST_UPD_DR: begin
                    // [R10] Commands without enable are ignored
                    if (prog_armed && ir == `INSN_ERASE) begin
                        // [R11] Whole array erased
                        for (i = 0; i < (1 << `ROW_ADDR_WIDTH); i = i + 1) begin
                            rows[i] <= {`ROW_WIDTH{1'b1}};
                        end
                    end else if (prog_armed && ir == `INSN_PROGRAM) begin
                        // [R12] Shifter written to addressed row
                        rows[row_addr] <= prog_shift;
                    end
                end
                default: ;
            endcase
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            row_read_data <= {`ROW_WIDTH{1'b0}};
        end else begin
            row_read_data <= rows[row_addr];
        end
    end

    // ========================================================
    // Output on falling tck
    // ========================================================
    reg data_out;
    always @* begin
        if (state == `ST_SHIFT_IR) begin
            data_out = ir_shift[0];
        end else if (is_id) begin
            data_out = id_shift[0];
        end else if (is_prog) begin
            data_out = prog_shift[0];
        end else begin
            data_out = bypass_bit;
        end
    end

    // [R6] [R7] Update on falling tck, drive only while shifting
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (port_off) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= data_out;
            tdo_oe <= (state == `ST_SHIFT_DR) || (state == `ST_SHIFT_IR);
        end
    end

    // [R8] Relies on tms high outside use
endmodule

//--- logic/tap_port_regs.vh
// Constants for the test access port: instruction codes, TAP states, widths.
// Included by the port logic only; no processes here.
`ifndef TAP_PORT_REGS_VH
`define TAP_PORT_REGS_VH

`define IR_WIDTH          4
`define INSN_BYPASS       4'hF
`define INSN_IDCODE       4'h1
`define INSN_ENABLE       4'h9
`define INSN_ERASE        4'hA
`define INSN_PROGRAM      4'hB
`define INSN_VERIFY       4'hC
`define IR_RESET_VALUE    4'h1
`define IR_CAPTURE_VALUE  4'h1
`define IDCODE_WIDTH      32
`define ROW_WIDTH         16
`define ROW_ADDR_WIDTH    4

`define ST_RESET          4'h0
`define ST_IDLE           4'h1
`define ST_SEL_DR         4'h2
`define ST_CAP_DR         4'h3
`define ST_SHIFT_DR       4'h4
`define ST_EXIT1_DR       4'h5
`define ST_PAUSE_DR       4'h6
`define ST_EXIT2_DR       4'h7
`define ST_UPD_DR         4'h8
`define ST_SEL_IR         4'h9
`define ST_CAP_IR         4'hA
`define ST_SHIFT_IR       4'hB
`define ST_EXIT1_IR       4'hC
`define ST_PAUSE_IR       4'hD
`define ST_EXIT2_IR       4'hE
`define ST_UPD_IR         4'hF

`endif

//--- sim/jtag_port_chk.sv
// Checker for the test access port, bound to its top module.
// Assumes sys_clk runs many times faster than tck.
module jtag_port_chk (
    input logic       sys_clk,
    input logic       rst,
    input logic       tck,
    input logic       tdo,
    input logic       tdo_oe,
    input logic       test_port_disable,
    input logic [3:0] user_out,
    input logic [3:0] user_oe,
    input logic [3:0] pin_out,
    input logic [3:0] pin_oe,
    input logic [3:0] buried_in,
    input logic       prog_armed
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Helper state
    logic       freed;
    logic [2:0] sync, since_fall, since_rise;
    // Same two-stage sync as the port, so edge ages line up
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            freed      <= 1'b0;
            sync       <= 3'h7;
            since_fall <= 3'h7;
            since_rise <= 3'h7;
        end else begin
            freed      <= freed | test_port_disable;
            sync       <= {sync[1:0], tck};
            since_fall <= (sync[2:1] == 2'h2) ? 3'h0 : since_fall + {2'h0, since_fall != 3'h7};
            since_rise <= (sync[2:1] == 2'h1) ? 3'h0 : since_rise + {2'h0, since_rise != 3'h7};
        end
    end
    // ========================================
    // Assertions
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_buried_follow: assert property (buried_in == user_out)
        else $error("buried input differs from user drive");
    chk_test_pins_held: assert property (!freed |-> pin_oe[3:1] == 3'h0)
        else $error("input pin driven in test mode");
    chk_tdo_on_pin: assert property (!freed |-> pin_oe[0] == tdo_oe && pin_out[0] == tdo)
        else $error("tdo pin drive wrong");
    chk_user_pins_free: assert property (freed |-> pin_oe == user_oe && pin_out == user_out)
        else $error("freed pins not under user drive");
    chk_tdo_after_fall: assert property ($changed({tdo, tdo_oe}) |-> since_fall <= 3'h2)
        else $error("tdo moved away from a tck fall");
    chk_armed_on_rise: assert property ($changed(prog_armed) |-> since_rise <= 3'h2)
        else $error("arming moved away from a tck rise");
    chk_reset_quiet: assert property ($fell(rst) |-> !tdo_oe && !prog_armed && !tdo)
        else $error("port not idle after reset");
    chk_freed_still: assert property (freed |=> $stable(tdo_oe) && $stable(prog_armed))
        else $error("freed port still reacts to tck");
    cover property (prog_armed && $rose(tdo_oe));
    cover property ($rose(freed));
    cover property ($rose(prog_armed));
endmodule

//--- sim/tap_ctrl_model.sv
// Behavioural test controller driving the serial link.
// Assumes pull-ups on the pins; a released tdo reads high.
module tap_ctrl_model (
    output logic tck,
    output logic tms,
    output logic tdi,
    input  logic tdo,
    input  logic tdo_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // Link driving
    wire tdo_wire = tdo_oe ? tdo : 1'b1;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // Sampled mid-high: tdo is settled long after the previous fall
    task automatic bit_cyc(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        #100 o = tdo_wire;
        #100 tck = 1'b0;
    endtask
    task automatic reset_tap();
        logic o;
        repeat (5) bit_cyc(1'b1, 1'b1, o);
        bit_cyc(1'b0, 1'b1, o);
    endtask
    // From idle to idle; tck stands low afterwards
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = 32'h0;
        bit_cyc(1'b1, 1'b1, o);
        if (ir) bit_cyc(1'b1, 1'b1, o);
        repeat (2) bit_cyc(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            bit_cyc(i == n - 1, din[i], o);
            dout[i] = o;
        end
        bit_cyc(1'b1, 1'b1, o);
        bit_cyc(1'b0, 1'b1, o);
        tms = 1'b1;
    endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the test access port.
// Assumes the port's tdo is read through the controller model.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ID  = 32'h0A5C_0F33; // Arbitrary value
    localparam logic [31:0] PAT = 32'hC3A5_96E1;
    localparam logic [31:0] BYP = {PAT[30:0], 1'b0};
    typedef struct {logic [3:0] code; logic [31:0] exp;} row_t;
    row_t rows [12] = '{'{4'h0, BYP}, '{4'h1, ID}, '{4'h2, BYP}, '{4'h3, BYP},
        '{4'h4, BYP}, '{4'h5, BYP}, '{4'h6, BYP}, '{4'h7, BYP}, '{4'h8, BYP},
        '{4'hD, BYP}, '{4'hE, BYP}, '{4'hF, BYP}};
    logic        sys_clk = 1'b0, rst = 1'b1, test_port_disable = 1'b0;
    logic [3:0]  user_out = 4'h6, user_oe = 4'h0, row_addr = 4'h3;
    logic [31:0] got;
    wire         tck, tms, tdi, tdo, tdo_oe, prog_armed;
    wire  [3:0]  pin_out, pin_oe, user_in, buried_in;
    wire  [15:0] row_read_data;
    int          n_fail = 0, n_checks = 0;
    always #25 sys_clk = ~sys_clk;
    jtag_isp_tap_port #(.ID_VALUE(ID)) i_jtag_isp_tap_port (.sys_clk, .rst, .tck, .tms,
        .tdi, .tdo, .tdo_oe, .test_port_disable, .user_out, .user_oe, .pin_out, .pin_oe,
        .user_in, .buried_in, .row_addr, .prog_armed, .row_read_data);
    tap_ctrl_model i_tap_ctrl_model (.tck, .tms, .tdi, .tdo, .tdo_oe);
    // ========================================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic sys_wait(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic load(input logic [3:0] code);
        logic [31:0] cap;
        i_tap_ctrl_model.scan(1'b1, 4, {28'h0, code}, cap);
        check("ir capture", 32'h1, cap);
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        i_tap_ctrl_model.scan(1'b0, n, din, got);
    endtask
    // ========================================
    // Sequence
    initial begin
        sys_wait(5);
        rst = 1'b0;
        i_tap_ctrl_model.reset_tap();
        dr(32, PAT);
        check("id after reset", ID, got);
        foreach (rows[k]) begin
            load(rows[k].code);
            dr(32, PAT);
            check("dr scan", rows[k].exp, got);
        end
        check("tdo_oe idle", 0, tdo_oe);
        load(4'hA);
        dr(16, 0);
        load(4'hB);
        dr(16, 32'h1234);
        sys_wait(2);
        check("unarmed row", 0, row_read_data);
        load(4'h9);
        check("armed", 1, prog_armed);
        load(4'hA);
        dr(16, 0);
        sys_wait(2);
        check("erased row", 32'hFFFF, row_read_data);
        load(4'hB);
        dr(16, 32'h5A3C);
        sys_wait(2);
        check("programmed row", 32'h5A3C, row_read_data);
        row_addr = 4'h4;
        sys_wait(2);
        check("other row", 32'hFFFF, row_read_data);
        row_addr = 4'h3;
        load(4'hC);
        dr(16, 0);
        check("verify out", 32'h5A3C, got);
        rst = 1'b1;
        sys_wait(2);
        rst = 1'b0;
        sys_wait(2);
        check("armed cleared", 0, prog_armed);
        i_tap_ctrl_model.reset_tap();
        dr(32, PAT);
        check("id after rerun", ID, got);
        check("buried", 32'h6, buried_in);
        user_out = 4'hA;
        user_oe = 4'h5;
        test_port_disable = 1'b1;
        sys_wait(2);
        check("pin_oe", 32'h5, pin_oe);
        check("pin_out", 32'hA, pin_out);
        check("user_in", 32'h6, user_in);
        give_verdict();
    end
    // Roughly 815 tck periods are needed; allow ample margin
    initial begin
        #2_000_000;
        n_fail++;
        give_verdict();
    end
endmodule
bind jtag_isp_tap_port jtag_port_chk i_jtag_port_chk (.sys_clk, .rst, .tck, .tdo, .tdo_oe,
    .test_port_disable, .user_out, .user_oe, .pin_out, .pin_oe, .buried_in, .prog_armed);
